// file: pkg/itis_pkg.sv
/*
 * Constants for the two-wire target interrupt-enable and bus-status block:
 * register offsets, bit positions, reset values and command codes.
 * Assumes an AXI4-Lite slave with 32-bit data and byte addresses.
 */
// Notes on behaviour
// - Writing ones to enable-clear disables those interrupts; zeros leave enables alone.
// - Enable-clear and enable-set share one enable set; reads show enabled bits.
// - Enable-clear at 0x14, resets to 0x00, writes ignored under write protection.
// - Bit 7 clears the error interrupt enable.
// - Bit 2 clears the data-ready interrupt enable.
// - Bit 1 clears the address-match interrupt enable.
// - Bit 0 clears the stop-received interrupt enable.
// - Collision on last sent byte sets sticky flag; write one clears it.
// - Illegal start, repeated start or stop sets bus-error, status bit 0.
// - Start directly followed by stop is a bus error.
// - Time-out during a frame is a bus error.
// - Bus-error auto-clears on command 0x3 or address-match flag clear.
// - Writing one to bus-error clears it; zero leaves it.
package itis_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ITIS_OFS_CMD     = 8'h04;
  localparam logic [7:0] ITIS_OFS_ENCLR   = 8'h14;
  localparam logic [7:0] ITIS_OFS_ENSET   = 8'h18;
  localparam logic [7:0] ITIS_OFS_FLAGS   = 8'h1C;
  localparam logic [7:0] ITIS_OFS_STATUS  = 8'h20;
  localparam logic [7:0] ITIS_OFS_EVSTAT  = 8'h24;
  localparam logic [7:0] ITIS_OFS_EVMASK  = 8'h28;

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int         ITIS_BIT_ERROR   = 7;
  localparam int         ITIS_BIT_DATA_READY = 2;
  localparam int         ITIS_BIT_ADDR_MATCH = 1;
  localparam int         ITIS_BIT_STOP    = 0;
  localparam int         ITIS_BIT_BUS_ERROR = 0;
  localparam int         ITIS_BIT_COLL    = 1;
  localparam int         ITIS_CMD_LSB     = 16;
  localparam logic [1:0] ITIS_CMD_RESPOND = 2'h3;
  localparam logic [7:0] ITIS_EN_MASK     = 8'h87;
  localparam logic [7:0] ITIS_EN_RESET    = 8'h00;
  localparam logic [1:0] ITIS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ITIS_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ITIS_BUS_IDLE  = 3'b001,
    ITIS_BUS_START = 3'b010,
    ITIS_BUS_DATA  = 3'b100
  } itis_bus_state_t;

endpackage

// file: pkg/itis_evt_if.sv
/*
 * Interface carrying bus-condition events from the condition watcher
 * to the register file. Assumes both ends share mclk_in.
 */
`timescale 1ns/10ps
interface itis_evt_if;
  logic bus_error;  // One-cycle pulse on illegal condition
  logic in_frame;   // Level, frame under way
  modport src (output bus_error, output in_frame);
  modport dst (input bus_error, input in_frame);
endinterface

// file: hw/itis_cond_watch.sv
/*
 * Watches bus condition strobes and flags protocol violations:
 * stop right after start, misplaced stops, repeated starts
 * outside a frame, and frame time-outs. Assumes strobes are synchronous.
 */
`timescale 1ns/10ps
module itis_cond_watch
  import itis_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic reset_in,
  input  wire logic start_in,
  input  wire logic rstart_in,
  input  wire logic stop_in,
  input  wire logic byte_in,
  input  wire logic timeout_in,
  itis_evt_if.src   evt
);

  itis_bus_state_t state_reg;
  itis_bus_state_t state_next;
  logic            err_reg;
  logic            err_next;

  // ----------------------------------------------------------------
  // Condition tracking
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    err_next   = 1'b0;
    case (state_reg)
      ITIS_BUS_IDLE: begin
        if (rstart_in || stop_in) begin
          err_next = 1'b1;
        end else if (start_in) begin
          state_next = ITIS_BUS_START;
        end
      end
      ITIS_BUS_START: begin
        if (stop_in || timeout_in) begin
          err_next   = 1'b1;
          state_next = ITIS_BUS_IDLE;
        end else if (start_in || rstart_in) begin
          err_next = 1'b1;
        end else if (byte_in) begin
          state_next = ITIS_BUS_DATA;
        end
      end
      ITIS_BUS_DATA: begin
        if (timeout_in) begin
          err_next   = 1'b1;
          state_next = ITIS_BUS_IDLE;
        end else if (start_in) begin
          err_next = 1'b1;
        end else if (rstart_in) begin
          state_next = ITIS_BUS_START;
        end else if (stop_in) begin
          state_next = ITIS_BUS_IDLE;
        end
      end
      default: state_next = ITIS_BUS_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_reg <= ITIS_BUS_IDLE;
      err_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      err_reg   <= err_next;
    end
  end

  assign evt.bus_error = err_reg;
  assign evt.in_frame  = (state_reg != ITIS_BUS_IDLE);

endmodule

// file: hw/itis_top.sv
/*
 * Two-wire target interrupt-enable and bus-status block with an
 * AXI4-Lite register slave. Assumes the bus controller side supplies
 * synchronous condition strobes and the protection level from outside.
 */
`timescale 1ns/10ps
module itis_top
  import itis_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        write_protect_in,
  input  wire logic        start_in,
  input  wire logic        rstart_in,
  input  wire logic        stop_in,
  input  wire logic        byte_in,
  input  wire logic        timeout_in,
  input  wire logic        collision_in,
  input  wire logic [7:0]  flag_set_in,
  output logic             irq_out
);

  itis_evt_if evt ();

  itis_cond_watch u_watch (
    .mclk_in    (mclk_in),
    .reset_in   (reset_in),
    .start_in   (start_in),
    .rstart_in  (rstart_in),
    .stop_in    (stop_in),
    .byte_in    (byte_in),
    .timeout_in (timeout_in),
    .evt        (evt.src)
  );

  // ----------------------------------------------------------------
  // Block overview
  // ----------------------------------------------------------------
  // Registers, by byte offset:
  //   command      - target command, bits 17:16
  //   enable-clear - write one drops an enable
  //   enable-set   - write one raises an enable
  //   irq flags    - hardware sets, write one clears
  //   bus status   - bus error bit 0, collision bit 1
  //   event status - cleared by its own read
  //   event mask   - gates events onto irq
  // Both enable views read the same bits.
  // Only enable bits 7, 2, 1 and 0 exist.
  //
  // Write protection:
  //   Blocks enables and command only.
  //   Flag and status clears still act.
  //   A blocked write still answers OKAY.
  //
  // Write path:
  //   Address and data held separately.
  //   Either may come first; acts once both stand.
  //   Next write waits for the answer to go.
  //
  // Read path:
  //   Data latched when the address is taken.
  //   Unmapped offsets read zero with SLVERR.
  //
  // Bus error:
  //   Set two edges after a bad strobe.
  //   Cleared by write one, respond command,
  //   or clearing a pending address match.
  //   A new error in the clear cycle wins.
  //
  // Collision:
  //   Sticky; write one clears; set wins.
  //   Also copied to event status bit 1.
  //
  // Interrupt:
  //   Next values, so no lag; mask changes lag one.
  //   Flags and enables, or events and mask.

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  aw_addr_reg;
  logic        aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_have_reg;
  logic [7:0]  enable_reg;
  logic [7:0]  irq_flags_reg;
  logic        bus_error_flag_reg;
  logic        coll_reg;
  logic [1:0]  target_command_field_reg;
  logic [1:0]  ev_stat_reg;
  logic [1:0]  ev_mask_reg;

  // ----------------------------------------------------------------
  // Write decode: acts once both address and data are held
  // ----------------------------------------------------------------
  wire        wr_go    = aw_have_reg && w_have_reg && !s_axi_bvalid_out;
  wire        wr_b0    = wr_go && w_strb_reg[0];
  wire        wr_b2    = wr_go && w_strb_reg[2];
  wire        wr_ok    = !write_protect_in;
  wire        wr_clr   = wr_b0 && wr_ok && (aw_addr_reg == ITIS_OFS_ENCLR);
  wire        wr_set   = wr_b0 && wr_ok && (aw_addr_reg == ITIS_OFS_ENSET);
  wire        wr_flag  = wr_b0 && (aw_addr_reg == ITIS_OFS_FLAGS);
  wire        wr_stat  = wr_b0 && (aw_addr_reg == ITIS_OFS_STATUS);
  wire        wr_mask  = wr_b0 && (aw_addr_reg == ITIS_OFS_EVMASK);
  wire        wr_cmd   = wr_b2 && wr_ok && (aw_addr_reg == ITIS_OFS_CMD);
  wire [7:0]  wbyte    = w_data_reg[7:0];
  wire [1:0]  cmd_val  = w_data_reg[ITIS_CMD_LSB+1:ITIS_CMD_LSB];
  wire        wr_known = (aw_addr_reg == ITIS_OFS_ENCLR) || (aw_addr_reg == ITIS_OFS_ENSET)
                      || (aw_addr_reg == ITIS_OFS_FLAGS) || (aw_addr_reg == ITIS_OFS_STATUS)
                      || (aw_addr_reg == ITIS_OFS_CMD) || (aw_addr_reg == ITIS_OFS_EVMASK)
                      || (aw_addr_reg == ITIS_OFS_EVSTAT);

  // Address-match flag being cleared by software
  // Only a flag that is really set counts as cleared
  wire address_match_irq_clr = wr_flag && wbyte[ITIS_BIT_ADDR_MATCH] && irq_flags_reg[ITIS_BIT_ADDR_MATCH];
  wire respond    = wr_cmd && (cmd_val == ITIS_CMD_RESPOND);

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Decode runs off the live address; it is
  // only used in the cycle the address is taken.
  // Reserved bits always read as zero.
  wire rd_go = s_axi_arvalid_in && s_axi_arready_out;
  wire [7:0] status_byte = {6'h00, coll_reg, bus_error_flag_reg};
  logic [31:0] rd_data;
  logic        rd_known;
  always_comb begin
    rd_data  = 32'h0000_0000;
    rd_known = 1'b1;
    if (s_axi_araddr_in == ITIS_OFS_ENCLR || s_axi_araddr_in == ITIS_OFS_ENSET) begin
      rd_data[7:0] = enable_reg;
    end else if (s_axi_araddr_in == ITIS_OFS_FLAGS) begin
      rd_data[7:0] = irq_flags_reg;
    end else if (s_axi_araddr_in == ITIS_OFS_STATUS) begin
      rd_data[7:0] = status_byte;
    end else if (s_axi_araddr_in == ITIS_OFS_CMD) begin
      rd_data[ITIS_CMD_LSB+1:ITIS_CMD_LSB] = target_command_field_reg;
    end else if (s_axi_araddr_in == ITIS_OFS_EVSTAT) begin
      rd_data[1:0] = ev_stat_reg;
    end else if (s_axi_araddr_in == ITIS_OFS_EVMASK) begin
      rd_data[1:0] = ev_mask_reg;
    end else begin
      rd_known = 1'b0;
    end
  end
  wire rd_evstat = rd_go && (s_axi_araddr_in == ITIS_OFS_EVSTAT);

  // ----------------------------------------------------------------
  // Next values of the control and status bits
  // ----------------------------------------------------------------
  wire [7:0] enable_next = wr_clr ? (enable_reg & ~(wbyte & ITIS_EN_MASK))
                         : wr_set ? (enable_reg | (wbyte & ITIS_EN_MASK))
                         : enable_reg;
  // Hardware set wins over a same-cycle write-one clear
  wire [7:0] flags_next  = (irq_flags_reg & ~(wr_flag ? wbyte : 8'h00)) | (flag_set_in & ITIS_EN_MASK)
                         | (evt.bus_error ? (8'h01 << ITIS_BIT_ERROR) : 8'h00);
  wire       bus_error_flag_clr  = (wr_stat && wbyte[ITIS_BIT_BUS_ERROR]) || respond || address_match_irq_clr;
  wire       bus_error_flag_next = evt.bus_error || (bus_error_flag_reg && !bus_error_flag_clr);
  wire       coll_next   = collision_in || (coll_reg && !(wr_stat && wbyte[ITIS_BIT_COLL]));
  // Read of the event register clears it; a new event in that cycle survives
  wire [1:0] ev_new      = {collision_in, evt.bus_error};
  wire [1:0] ev_next     = ev_new | (rd_evstat ? 2'h0 : ev_stat_reg);

  // ----------------------------------------------------------------
  // AXI write channel holding
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr_in[7:2], 2'h0};
      end else if (wr_go) begin
        aw_have_reg <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end else if (wr_go) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI handshakes and responses
  // ----------------------------------------------------------------
  // Readies are registered: one item per channel
  // at most every third cycle, traded for flop outputs.
  // Write, both channels together:
  //   edge 1 - taken, readies drop
  //   edge 2 - registers move, bvalid rises
  //   edge 3 - bvalid drops if bready high
  // Read:
  //   edge 1 - taken, rvalid rises with data
  //   edge 2 - rvalid drops if rready high
  // Code and data hold while valid stands.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= ITIS_RESP_OKAY;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rresp_out   <= ITIS_RESP_OKAY;
      s_axi_rdata_out   <= 32'h0000_0000;
    end else begin
      s_axi_awready_out <= !aw_have_reg && !(s_axi_awvalid_in && s_axi_awready_out);
      s_axi_wready_out  <= !w_have_reg && !(s_axi_wvalid_in && s_axi_wready_out);
      if (wr_go) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_known ? ITIS_RESP_OKAY : ITIS_RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
      s_axi_arready_out <= !s_axi_rvalid_out && !rd_go;
      if (rd_go) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= rd_data;
        s_axi_rresp_out  <= rd_known ? ITIS_RESP_OKAY : ITIS_RESP_SLVERR;
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Enables, flags, status and interrupt
  // ----------------------------------------------------------------
  // All state resets to zero, every interrupt off.
  // Command field keeps the last value written;
  // only the respond code has a side effect.
  // Hazards:
  //   Flag set and clear together - set wins.
  //   Event and status read together - event stays.
  //   Error and respond together - error stays.
  // Limitation: the two-wire lines are not seen
  // here, only the controller's strobes.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      enable_reg               <= ITIS_EN_RESET;
      irq_flags_reg            <= 8'h00;
      bus_error_flag_reg       <= 1'b0;
      coll_reg                 <= 1'b0;
      target_command_field_reg <= 2'h0;
      ev_stat_reg              <= 2'h0;
      ev_mask_reg              <= 2'h0;
      irq_out                  <= 1'b0;
    end else begin
      enable_reg         <= enable_next;
      irq_flags_reg      <= flags_next;
      bus_error_flag_reg <= bus_error_flag_next;
      coll_reg           <= coll_next;
      ev_stat_reg        <= ev_next;
      if (wr_cmd) begin
        target_command_field_reg <= cmd_val;
      end
      if (wr_mask) begin
        ev_mask_reg <= wbyte[1:0];
      end
      // Registered so the output stays glitch free; next values keep it in step
      irq_out <= (|(flags_next & enable_next)) || (|(ev_next & ev_mask_reg));
    end
  end

endmodule

// file: tb/itis_top_checker.sv
/*
 * Concurrent checks on the itis_top register bus, reset and response codes.
 * Assumes it is bound onto itis_top and sees one clock domain.
 */
`timescale 1ns/10ps
module itis_top_checker
  import itis_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        reset_in,
  input wire logic [7:0]  s_axi_awaddr_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        irq_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // Answers stand until the master takes them
  a_bresp_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer not held");
  a_rdata_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer not held");
  // Bounded answer after a request is taken
  a_write_answered: assert property (s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out |-> ##[1:4] s_axi_bvalid_out)
    else $error("write not answered");
  a_read_answered: assert property (s_axi_arvalid_in && s_axi_arready_out
    |-> ##[1:4] s_axi_rvalid_out) else $error("read not answered");
  // One transfer of each kind at a time
  a_write_single: assert property (s_axi_bvalid_out |-> !s_axi_awready_out)
    else $error("address ready while answer pending");
  a_read_single: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read ready while data pending");
  // Quiet outputs just after reset: no answers pending, irq low
  a_reset_quiet: assert property ($fell(reset_in) |->
    !s_axi_bvalid_out && !s_axi_rvalid_out && !irq_out) else $error("outputs busy after reset");
  a_unmapped_err: assert property (s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_awaddr_in == 8'h3C |-> ##[1:4] s_axi_bvalid_out && s_axi_bresp_out == ITIS_RESP_SLVERR)
    else $error("unmapped write not refused");
endmodule

bind itis_top itis_top_checker itis_top_checker_inst (
  .mclk_in(mclk_in), .reset_in(reset_in), .s_axi_awaddr_in(s_axi_awaddr_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in), .irq_out(irq_out));

// file: tb/itis_bus_model.sv
/*
 * Stand-in for the two-wire bus controller: issues one-cycle condition
 * strobes. Assumes a caller invokes cond() right after a clock edge.
 */
`timescale 1ns/10ps
module itis_bus_model (
  input  wire logic mclk_in,
  output logic      start_out,
  output logic      rstart_out,
  output logic      stop_out,
  output logic      byte_out,
  output logic      timeout_out,
  output logic      collision_out
);
  // Strobes idle low outside a condition
  initial begin
    {start_out, rstart_out, stop_out, byte_out, timeout_out, collision_out} = 6'h00;
  end

  // One strobe for one cycle, then a quiet cycle before the next
  task cond(input logic [5:0] c);
    @(posedge mclk_in);
    {start_out, rstart_out, stop_out, byte_out, timeout_out, collision_out} <= c;
    @(posedge mclk_in);
    {start_out, rstart_out, stop_out, byte_out, timeout_out, collision_out} <= 6'h00;
  endtask
endmodule

// file: tb/tb_top.sv
/*
 * Self-checking bench for itis_top: AXI4-Lite tasks and one task per scenario.
 * Assumes itis_bus_model supplies the bus condition strobes.
 */
`timescale 1ns/10ps
module tb_top;
  import itis_pkg::*;
  localparam logic [5:0] C_START = 6'h20, C_RSTART = 6'h10, C_STOP = 6'h08;
  localparam logic [5:0] C_BYTE = 6'h04, C_TOUT = 6'h02, C_COLL = 6'h01;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, wprot, irq, st, rs, sp, by, to, co;
  logic [7:0]  awaddr, araddr, flag_set;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  int          miscompares, tests_run;
  int          bits [4] = '{7, 2, 1, 0};

  // Free-running clock, 40 ns period
  always #20 clk = ~clk;

  itis_bus_model itis_bus_model_inst (.mclk_in(clk), .start_out(st), .rstart_out(rs),
    .stop_out(sp), .byte_out(by), .timeout_out(to), .collision_out(co));
  itis_top itis_top_inst (.mclk_in(clk), .reset_in(rst), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .write_protect_in(wprot), .start_in(st), .rstart_in(rs),
    .stop_in(sp), .byte_in(by), .timeout_in(to), .collision_in(co),
    .flag_set_in(flag_set), .irq_out(irq));

  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Write: both channels offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // Read: address held until taken, data taken with rvalid
  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task pulse_flag(input logic [7:0] f);
    flag_set <= f;
    @(posedge clk);
    flag_set <= 8'h00;
  endtask

  // Enable bits: reset value, shared view, clear-by-one, protection
  task t_enables;
    logic [7:0] en;
    rd(ITIS_OFS_ENCLR);
    chk(got, 32'h0000_0000);
    rd(8'h3C);
    chk({30'h0, resp}, {30'h0, ITIS_RESP_SLVERR});
    wr(8'h3C, 32'h0000_0087);
    chk({30'h0, resp}, {30'h0, ITIS_RESP_SLVERR});
    wr(ITIS_OFS_ENSET, 32'h0000_00FF);
    wr(ITIS_OFS_ENCLR, 32'h0000_0000);
    rd(ITIS_OFS_ENCLR);
    chk(got, 32'h0000_0087);
    en = 8'h87;
    foreach (bits[i]) begin
      en = en & ~(8'h01 << bits[i]);
      wr(ITIS_OFS_ENCLR, 32'h0000_0001 << bits[i]);
      rd(ITIS_OFS_ENSET);
      chk(got, {24'h0, en});
    end
    wprot <= 1'b1;
    wr(ITIS_OFS_ENSET, 32'h0000_0087);
    wprot <= 1'b0;
    rd(ITIS_OFS_ENCLR);
    chk(got, 32'h0000_0000);
  endtask

  // Bus error: three illegal conditions, three ways to clear
  task t_bus_error;
    itis_bus_model_inst.cond(C_START);
    itis_bus_model_inst.cond(C_STOP);
    rd(ITIS_OFS_STATUS);
    chk(got, 32'h0000_0001);
    wr(ITIS_OFS_STATUS, 32'h0000_0000);
    rd(ITIS_OFS_STATUS);
    chk(got, 32'h0000_0001);
    wr(ITIS_OFS_STATUS, 32'h0000_0001);
    rd(ITIS_OFS_STATUS);
    chk(got, 32'h0000_0000);
    itis_bus_model_inst.cond(C_RSTART);
    pulse_flag(8'h02);
    rd(ITIS_OFS_STATUS);
    chk(got, 32'h0000_0001);
    wr(ITIS_OFS_FLAGS, 32'h0000_0002);
    rd(ITIS_OFS_STATUS);
    chk(got, 32'h0000_0000);
    itis_bus_model_inst.cond(C_START);
    itis_bus_model_inst.cond(C_BYTE);
    itis_bus_model_inst.cond(C_TOUT);
    rd(ITIS_OFS_STATUS);
    chk(got, 32'h0000_0001);
    wr(ITIS_OFS_CMD, {14'h0, ITIS_CMD_RESPOND, 16'h0});
    rd(ITIS_OFS_STATUS);
    chk(got, 32'h0000_0000);
  endtask

  // Interrupt line follows flag and enable together
  task t_irq;
    wr(ITIS_OFS_ENSET, 32'h0000_0004);
    pulse_flag(8'h04);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(ITIS_OFS_ENCLR, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(ITIS_OFS_ENSET, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(ITIS_OFS_FLAGS, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask

  // Collision: sticky bit, masked event, read-clear event status
  task t_collision;
    rd(ITIS_OFS_EVSTAT);
    itis_bus_model_inst.cond(C_COLL);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(ITIS_OFS_STATUS);
    chk(got, 32'h0000_0002);
    wr(ITIS_OFS_STATUS, 32'h0000_0000);
    rd(ITIS_OFS_STATUS);
    chk(got, 32'h0000_0002);
    wr(ITIS_OFS_EVMASK, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(ITIS_OFS_EVSTAT);
    chk(got, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(ITIS_OFS_STATUS, 32'h0000_0002);
    rd(ITIS_OFS_STATUS);
    chk(got, 32'h0000_0000);
  endtask

  task end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence: six cycles of reset, then the scenarios
  initial begin
    {clk, rst, awvalid, wvalid, bready, arvalid, rready, wprot} = 8'h40;
    {awaddr, araddr, flag_set, wdata, wstrb} = {24'h0, 32'h0, 4'hF};
    miscompares = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_enables;
    t_bus_error;
    t_irq;
    t_collision;
    end_sim;
  end

  // Watchdog, well beyond the fewer than two hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim;
  end
endmodule
